// file: mcam_pkg.sv
// Function
// - Add signed offset register to every Remote 2 result; one count is half a degree.
// - Once lock bit is one, writes to lockable config and mask registers are ignored.
// - Averaging-disable bit 4 stops averaging so channels convert faster.
// - Attenuator-bypass bit 5 disconnects the processor-rail input attenuator.
// - Single-channel bit 6 converts one input repeatedly, chosen by select bits.
// - Select codes: 001 rail, 010 supply, 101 Remote 1, 110 local, 111 Remote 2.
// - Shutdown bit 7 drives every fan output to its off level per invert.
// - In shutdown every current duty-cycle register reads zero.
// - Mask one bits 1,2,4,5,6 block alert for their channel limit events.
// - Mask one bit 7 gates status two summary when mask two bits 2-7 are all set.
// - Mask two bit 1 masks overtemperature and is read-only; bits 2-4 fans 1-3.
// - Mask two bit 5 masks fan 4 fault, or thermal timer when pin is thermal.
// - Mask two bits 6 and 7 mask Remote 1 and Remote 2 diode faults.
// - Voltage low-bits register: rail bits 3:2, supply bits 5:4.
// - Temperature low-bits register: bits 3:2, local 5:4, 7:6.
// - Reading a low-bits register freezes it and its high bytes until those are read or the other low-bits register is read.
package mcam_pkg;
  localparam logic [7:0] ADDR_R2_OFFSET = 8'h72;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
  localparam logic [7:0] ADDR_VOLT_LOW = 8'h76;
  localparam logic [7:0] ADDR_TEMP_LOW = 8'h77;
  localparam logic [7:0] ADDR_RAIL_HIGH = 8'h21;
  localparam logic [7:0] ADDR_SUPPLY_HIGH = 8'h22;
  localparam logic [7:0] ADDR_R1_HIGH = 8'h25;
  localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h26;
  localparam logic [7:0] ADDR_R2_HIGH = 8'h27;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] CONFIG_TWO_WMASK = 8'hF0;
  localparam logic [7:0] MASK_TWO_WMASK = 8'hFC;
  localparam logic [7:0] MASK_TWO_ALL = 8'hFE;
  localparam logic [7:0] MASK_ONE_CHAN = 8'h76;
  localparam int CFG_AVG_BIT = 4;
  localparam int CFG_ATTENUATOR_BYPASS_BIT = 5;
  localparam int CFG_SINGLE_CHANNEL_CONVERT_BIT = 6;
  localparam int CFG_SHUTDOWN_REQUEST_BIT = 7;
  localparam int MASK1_GATE_BIT = 7;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam logic [2:0] SEL_RAIL = 3'h1;
  localparam logic [2:0] SEL_SUPPLY = 3'h2;
  localparam logic [2:0] SEL_R1 = 3'h5;
  localparam logic [2:0] SEL_LOCAL = 3'h6;
  localparam logic [2:0] SEL_R2 = 3'h7;
  localparam int NUM_CH = 5;
  localparam int NUM_FANS = 4;

  // Channel order: rail, supply, remote1, local, remote2
  typedef struct packed {
    logic [NUM_CH-1:0] valid;
    logic [NUM_CH-1:0][9:0] value;
  } mcam_results_t;

  typedef struct packed {
    logic averaging_disable;
    logic attenuator_bypass;
    logic single_channel_convert;
    logic shutdown_request;
    logic [2:0] channel_select;
  } mcam_single_channel_convert_ctrl_t;

  typedef enum logic [1:0] {
    FRZ_IDLE = 2'b00,
    FRZ_VOLT = 2'b01,
    FRZ_TEMP = 2'b11
  } mcam_freeze_t;
endpackage

// file: mcam_regs.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module mcam_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Lock and pin function
  input wire logic config_lock,
  input wire logic fourth_tach_is_thermal,
  input wire logic output_invert,
  input wire logic [2:0] channel_select_in,
  // Conversion results
  input wire mcam_pkg::mcam_results_t raw_results,
  input wire logic [7:0] duty_in_0,
  input wire logic [7:0] duty_in_1,
  input wire logic [7:0] duty_in_2,
  input wire logic [7:0] duty_in_3,
  // Status flags
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  // Outputs
  output mcam_pkg::mcam_single_channel_convert_ctrl_t single_channel_convert_ctrl,
  output logic [mcam_pkg::NUM_FANS-1:0] fan_drive,
  output logic [mcam_pkg::NUM_FANS*8-1:0] duty_readback,
  output logic alert_q
);
  import mcam_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] r2_offset_q;
  logic [7:0] config_two_q;
  logic [7:0] mask_one_q;
  logic [7:0] mask_two_q;
  logic [NUM_CH-1:0][9:0] held_q;
  mcam_freeze_t freeze_q;
  logic [NUM_CH-1:0] pending_q;
  logic [9:0] r2_adj;
  logic [7:0] rdata_d;
  logic wr_ok;
  logic [NUM_FANS*8-1:0] duty_raw;

  assign wr_ok = reg_wr & ~config_lock;
  assign duty_raw = {duty_in_3, duty_in_2, duty_in_1, duty_in_0};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r2_offset_q <= RESET_BYTE;
      config_two_q <= RESET_BYTE;
      mask_one_q <= RESET_BYTE;
      mask_two_q <= RESET_BYTE;
    end else if (clk_en && wr_ok) begin
      if (reg_addr == ADDR_R2_OFFSET) begin
        r2_offset_q <= reg_wdata;
      end else if (reg_addr == ADDR_CONFIG_TWO) begin
        config_two_q <= reg_wdata & CONFIG_TWO_WMASK;
      end else if (reg_addr == ADDR_MASK_ONE) begin
        mask_one_q <= reg_wdata;
      end else if (reg_addr == ADDR_MASK_TWO) begin
        mask_two_q <= reg_wdata & MASK_TWO_WMASK;
      end
    end
  end

  // ----------------------------------------
  // Offset and result freeze
  // ----------------------------------------
  // Offset in half degrees added to 10-bit quarter-degree result
  // Sign extended so a negative offset subtracts
  assign r2_adj = raw_results.value[4] + {r2_offset_q[7], r2_offset_q, 1'b0};

  // Which freeze group a channel belongs to
  function automatic logic in_group(input int ch, input mcam_freeze_t g);
    in_group = (g == FRZ_VOLT) ? (ch < 2) : ((g == FRZ_TEMP) ? (ch >= 2) : 1'b0);
  endfunction

  // Low-byte read in flight: hold its group this cycle too, so the
  // high bytes match the low bits already on their way to the host
  function automatic logic low_read(input int ch);
    low_read = reg_rd && (((reg_addr == ADDR_VOLT_LOW) && (ch < 2))
               || ((reg_addr == ADDR_TEMP_LOW) && (ch >= 2)));
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_hold
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          held_q[gi] <= 10'h000;
        end else if (clk_en && raw_results.valid[gi] && !low_read(gi)
                     && !(in_group(gi, freeze_q) && pending_q[gi])) begin
          held_q[gi] <= (gi == 4) ? r2_adj : raw_results.value[gi];
        end
      end
    end
  endgenerate

  // High-byte address to channel index
  function automatic int high_index(input logic [7:0] a);
    if (a == ADDR_RAIL_HIGH) high_index = 0;
    else if (a == ADDR_SUPPLY_HIGH) high_index = 1;
    else if (a == ADDR_R1_HIGH) high_index = 2;
    else if (a == ADDR_LOCAL_HIGH) high_index = 3;
    else if (a == ADDR_R2_HIGH) high_index = 4;
    else high_index = NUM_CH;
  endfunction

  // Freeze releases once every high byte of the group has been read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      freeze_q <= FRZ_IDLE;
      pending_q <= '0;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == ADDR_VOLT_LOW) begin
        freeze_q <= FRZ_VOLT;
        pending_q <= 5'b00011;
      end else if (reg_addr == ADDR_TEMP_LOW) begin
        freeze_q <= FRZ_TEMP;
        pending_q <= 5'b11100;
      end else if (high_index(reg_addr) < NUM_CH) begin
        pending_q[high_index(reg_addr)] <= 1'b0;
        if ((pending_q & ~(5'b00001 << high_index(reg_addr))) == '0) begin
          freeze_q <= FRZ_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_R2_OFFSET) begin
      rdata_d = r2_offset_q;
    end else if (reg_addr == ADDR_CONFIG_TWO) begin
      rdata_d = config_two_q;
    end else if (reg_addr == ADDR_MASK_ONE) begin
      rdata_d = mask_one_q;
    end else if (reg_addr == ADDR_MASK_TWO) begin
      rdata_d = mask_two_q;
    end else if (reg_addr == ADDR_VOLT_LOW) begin
      rdata_d = {2'b00, held_q[1][1:0], held_q[0][1:0], 2'b00};
    end else if (reg_addr == ADDR_TEMP_LOW) begin
      rdata_d = {held_q[4][1:0], held_q[3][1:0], held_q[2][1:0], 2'b00};
    end else if (high_index(reg_addr) < NUM_CH) begin
      rdata_d = held_q[high_index(reg_addr)][9:2];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      single_channel_convert_ctrl <= '0;
    end else if (clk_en) begin
      single_channel_convert_ctrl.averaging_disable <= config_two_q[CFG_AVG_BIT];
      single_channel_convert_ctrl.attenuator_bypass <= config_two_q[CFG_ATTENUATOR_BYPASS_BIT];
      single_channel_convert_ctrl.single_channel_convert <= config_two_q[CFG_SINGLE_CHANNEL_CONVERT_BIT];
      single_channel_convert_ctrl.shutdown_request <= config_two_q[CFG_SHUTDOWN_REQUEST_BIT];
      // Reserved codes fall back to the rail so the converter never idles
      case (channel_select_in)
        SEL_RAIL, SEL_SUPPLY, SEL_R1, SEL_LOCAL, SEL_R2: begin
          single_channel_convert_ctrl.channel_select <= channel_select_in;
        end
        default: begin
          single_channel_convert_ctrl.channel_select <= SEL_RAIL;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shutdown fan drive
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fan_drive <= '0;
      duty_readback <= '0;
    end else if (clk_en) begin
      if (config_two_q[CFG_SHUTDOWN_REQUEST_BIT]) begin
        fan_drive <= {NUM_FANS{output_invert}};
        duty_readback <= '0;
      end else begin
        fan_drive <= '0;
        duty_readback <= duty_raw;
      end
    end
  end

  // ----------------------------------------
  // Alert gating
  // ----------------------------------------
  logic one_hit;
  logic two_hit;
  logic two_all_masked;
  assign one_hit = |(status_one & MASK_ONE_CHAN & ~mask_one_q);
  // Fan 4 bit also covers the thermal timer when the pin is repurposed
  assign two_hit = |(status_two & MASK_TWO_ALL & ~mask_two_q);
  assign two_all_masked = ((mask_two_q & MASK_TWO_WMASK) == MASK_TWO_WMASK);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      alert_q <= 1'b0;
    end else if (clk_en) begin
      alert_q <= one_hit | two_hit
        | (two_all_masked && (|status_two) && !mask_one_q[MASK1_GATE_BIT]);
    end
  end

  logic unused_pin;
  assign unused_pin = fourth_tach_is_thermal;
endmodule

// file: mcam_host.sv
`timescale 1ns/1ps
// ----
// Register host
// ----
module mcam_host (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // Idle cycle after each strobe, so no signal is assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge core_clk);
  endtask
endmodule

// file: mcam_regs_sva.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module mcam_regs_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Inputs
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic config_lock,
  input wire logic output_invert,
  input wire logic [2:0] channel_select_in,
  input wire logic [7:0] duty_in_0,
  input wire logic [7:0] duty_in_1,
  input wire logic [7:0] duty_in_2,
  input wire logic [7:0] duty_in_3,
  input wire logic [7:0] status_one,
  input wire logic [7:0] status_two,
  // Outputs
  input wire logic [7:0] reg_rdata,
  input wire mcam_pkg::mcam_single_channel_convert_ctrl_t single_channel_convert_ctrl,
  input wire logic [mcam_pkg::NUM_FANS-1:0] fan_drive,
  input wire logic [31:0] duty_readback,
  input wire logic alert_q
);
  import mcam_pkg::*;
  logic [31:0] duties;
  logic rd_cfg;
  assign duties = {duty_in_3, duty_in_2, duty_in_1, duty_in_0};
  assign rd_cfg = reg_rd && reg_addr == ADDR_CONFIG_TWO;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Two settled cycles, as outputs lag their cause by one
  sequence s_off;
    (single_channel_convert_ctrl.shutdown_request && $stable(output_invert)) [*2];
  endsequence
  sequence s_on;
    (!single_channel_convert_ctrl.shutdown_request && $stable(duties)) [*2];
  endsequence
  a_shutdown_request_fans_off: assert property (s_off |-> fan_drive == {NUM_FANS{output_invert}})
    else $error("fans not off in shutdown");
  a_shutdown_request_duty_zero: assert property (s_off |-> duty_readback == 32'h0)
    else $error("duty not zero in shutdown");
  a_run_fans_idle: assert property (s_on |-> fan_drive == '0)
    else $error("fan override outside shutdown");
  a_run_duty_pass: assert property (s_on |-> duty_readback == duties)
    else $error("duty readback wrong");
  a_lock_cfg_held: assert property (config_lock [*3] |-> $stable(single_channel_convert_ctrl[6:3]))
    else $error("config changed while locked");
  a_cfg_bits_drive: assert property ($past(rd_cfg) |-> single_channel_convert_ctrl[6:3] ==
    {reg_rdata[4], reg_rdata[5], reg_rdata[6], reg_rdata[7]}) else $error("config bits wrong");
  a_select_decode: assert property ($stable(channel_select_in) [*2] |->
    single_channel_convert_ctrl.channel_select == ((channel_select_in inside {3'h0, 3'h3, 3'h4}) ?
    SEL_RAIL : channel_select_in)) else $error("select decode wrong");
  a_quiet_no_alert: assert property ((status_one == 8'h00 && status_two == 8'h00) [*2]
    |-> !alert_q) else $error("alert without event");
endmodule
bind mcam_regs mcam_regs_sva chk (.*);

// file: tb_monitor_config_alert_mask_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb_monitor_config_alert_mask_regs;
  import mcam_pkg::*;
  logic core_clk = 0, nrst = 0, clk_en = 1, config_lock = 0, pend = 0;
  logic fourth_tach_is_thermal = 0, output_invert = 0, reg_wr, reg_rd, alert_q;
  logic [2:0] channel_select_in = 3'h1;
  logic [7:0] status_one = '0, status_two = '0, reg_addr, reg_wdata, reg_rdata, x, o = '0;
  logic [7:0] duty_in_0 = '0, duty_in_1 = '0, duty_in_2 = '0, duty_in_3 = '0;
  mcam_results_t raw_results = '0;
  mcam_single_channel_convert_ctrl_t single_channel_convert_ctrl;
  logic [NUM_FANS-1:0] fan_drive;
  logic [31:0] duty_readback;
  logic [9:0] v[5], p[5];
  logic [15:0] q[$];
  logic [7:0] ra[4] = '{ADDR_R2_OFFSET, ADDR_CONFIG_TWO, ADDR_MASK_ONE, ADDR_MASK_TWO};
  logic [7:0] wm[4] = '{8'hFF, CONFIG_TWO_WMASK, 8'hFF, MASK_TWO_WMASK};
  logic [15:0] ab[11] = '{16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0040,
    16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000};
  int mismatches = 0, checks = 0;
  always #4 core_clk = ~core_clk;
  mcam_host host (.*);
  mcam_regs dut (.*);
  // ----
  // Read data checker
  // ----
  always @(posedge core_clk) begin
    if (pend) begin
      `CHK("rdata", q[0][7:0], reg_rdata)
      void'(q.pop_front());
    end
    pend <= reg_rd;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back({a, e});
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic pulse;
    for (int i = 0; i < 5; i++) v[i] = 10'($urandom);
    raw_results.value <= {v[4], v[3], v[2], v[1], v[0]};
    raw_results.valid <= 5'h1F;
    step(1);
    raw_results.valid <= 5'h00;
    v[4] = v[4] + {o[7], o, 1'b0};
    step(2);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    step(20000);
    mismatches++;
    results;
  end
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(32'hE4A2));
    {duty_in_3, duty_in_2, duty_in_1, duty_in_0} <= $urandom;
    step(2);
    nrst <= 1'b1;
    step(1);
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h80, 8'h00);
    foreach (ra[i]) begin
      x = 8'($urandom);
      host.xfer(1'b1, ra[i], x);
      rd(ra[i], x & wm[i]);
      config_lock <= 1'b1;
      host.xfer(1'b1, ra[i], ~x);
      rd(ra[i], x & wm[i]);
      config_lock <= 1'b0;
    end
    host.xfer(1'b1, ADDR_R2_OFFSET, 8'hA5);
    clk_en <= 1'b0;
    host.xfer(1'b1, ADDR_R2_OFFSET, 8'h5A);
    clk_en <= 1'b1;
    rd(ADDR_R2_OFFSET, 8'hA5);
    $display("test registers done");
    for (int b = 4; b < 8; b++) begin
      output_invert <= 1'($urandom);
      host.xfer(1'b1, ADDR_CONFIG_TWO, 8'h01 << b);
      step(2);
      `CHK("single_channel_convert", {b == 4, b == 5, b == 6, b == 7}, single_channel_convert_ctrl[6:3])
      `CHK("fans", b == 7 ? {NUM_FANS{output_invert}} : 4'h0, fan_drive)
      `CHK("duty", b == 7 ? 32'h0 : {duty_in_3, duty_in_2, duty_in_1, duty_in_0}, duty_readback)
    end
    for (int s = 0; s < 8; s++) begin
      channel_select_in <= 3'(s);
      step(3);
      `CHK("sel", s inside {0, 3, 4} ? SEL_RAIL : 3'(s), single_channel_convert_ctrl.channel_select)
    end
    $display("test config done");
    host.xfer(1'b1, ADDR_MASK_ONE, 8'h00);
    host.xfer(1'b1, ADDR_MASK_TWO, 8'h00);
    foreach (ab[i]) begin
      fourth_tach_is_thermal <= (i == 8);
      {status_two, status_one} <= ab[i];
      step(3);
      `CHK("alert", 1'b1, alert_q)
      host.xfer(1'b1, ADDR_MASK_ONE + 8'(i > 4), ab[i][7:0] | ab[i][15:8]);
      step(2);
      `CHK("masked", 1'b0, alert_q)
      host.xfer(1'b1, ADDR_MASK_ONE + 8'(i > 4), 8'h00);
    end
    {status_two, status_one} <= 16'h1000;
    host.xfer(1'b1, ADDR_MASK_TWO, 8'hFC);
    for (int g = 0; g < 2; g++) begin
      host.xfer(1'b1, ADDR_MASK_ONE, 8'(g) << 7);
      step(2);
      `CHK("gate", 1'(g == 0), alert_q)
    end
    status_two <= 8'h00;
    $display("test alert done");
    o = 8'($urandom);
    host.xfer(1'b1, ADDR_R2_OFFSET, o);
    pulse;
    rd(ADDR_VOLT_LOW, {2'h0, v[1][1:0], v[0][1:0], 2'h0});
    p = v;
    pulse;
    rd(ADDR_RAIL_HIGH, p[0][9:2]);
    rd(ADDR_SUPPLY_HIGH, p[1][9:2]);
    rd(ADDR_TEMP_LOW, {v[4][1:0], v[3][1:0], v[2][1:0], 2'h0});
    p = v;
    pulse;
    rd(ADDR_R1_HIGH, p[2][9:2]);
    rd(ADDR_LOCAL_HIGH, p[3][9:2]);
    rd(ADDR_R2_HIGH, p[4][9:2]);
    pulse;
    rd(ADDR_TEMP_LOW, {v[4][1:0], v[3][1:0], v[2][1:0], 2'h0});
    $display("test results done");
    for (int i = 0; i < 8 && q.size() > 0; i++) step(1);
    if (q.size() > 0) mismatches++;
    results;
  end
endmodule
